// *** hw/rscl_latch.sv ***
`timescale 1ns/10ps

module rscl_latch (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Strap pins
	input wire logic strap_flow_ctrl,
	input wire logic strap_bcast_storm,
	input wire logic strap_buffer_share,
	input wire logic strap_addr_aging,
	input wire logic strap_frame_len,
	input wire logic strap_backpressure,
	input wire logic strap_uplink_speed,
	input wire logic strap_uplink_duplex,
	input wire logic strap_uplink_pause,
	input wire logic strap_uplink_reserved,
	input wire logic tag_priority_enable,
	input wire logic [1:0] uplink_port_mode,
	input wire logic priority_buffer_reserve,
	input wire logic program_interface_select,
	input wire logic auto_crossover_enable,
	input wire logic far_end_fault,
	input wire logic factory_test_enable,
	input wire logic scan_chain_enable,
	input wire logic remote_loopback_test,
	input wire logic switch_mode_test,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Configuration to the switch core
	output logic config_valid,
	output logic flow_ctrl_en,
	output logic bcast_limit_en,
	output logic [6:0] bcast_limit_pct,
	output logic buffer_equal_alloc,
	output logic [9:0] port_buffer_limit,
	output logic addr_aging_en,
	output logic [8:0] aging_seconds,
	output logic [10:0] max_len_untagged,
	output logic [10:0] max_len_tagged,
	output logic backpressure_en,
	// Uplink port
	output logic uplink_speed_100,
	output logic uplink_full_duplex,
	output logic uplink_pause_en,
	output logic uplink_disabled,
	output logic uplink_reverse_mii,
	output logic uplink_forward_mii,
	output logic uplink_serial_mode,
	// Priority
	output logic qos_enable,
	output logic [7:0] priority_high_map,
	output logic priority_reserve_en,
	output logic [12:0] priority_reserve_bytes,
	// Programming interface and transceivers
	output logic processor_if_sel,
	output logic serial_prog_used,
	output logic auto_crossover_en,
	output logic far_end_fault_en,
	// Board strapping health
	output logic strap_reserved_fault,
	output logic strap_test_fault
);

	typedef struct packed {
		logic [20:0] sync1;
		logic [20:0] sync2;
		rscl_pkg::rscl_state_t state;
		logic [1:0] fill;
		logic [20:0] cfg;
		logic [15:0] ovr;
		logic [31:0] rdata;
		logic [31:0] effect;
	} rscl_regs_t;

	rscl_regs_t s;
	rscl_regs_t next_s;
	logic [20:0] pins;
	logic [20:0] c;
	logic pri_en;
	logic rsv_en;
	logic [7:0] pri_map;
	logic mapped;
	logic [31:0] status;

	// ----------------------------------------
	// Pin gathering
	// ----------------------------------------
	// one bit per strap
	always_comb begin
		pins = '0;
		pins[rscl_pkg::BIT_FLOW] = strap_flow_ctrl;
		pins[rscl_pkg::BIT_BCAST] = strap_bcast_storm;
		pins[rscl_pkg::BIT_BUFSHARE] = strap_buffer_share;
		pins[rscl_pkg::BIT_AGING] = strap_addr_aging;
		pins[rscl_pkg::BIT_FRAMELEN] = strap_frame_len;
		pins[rscl_pkg::BIT_BACKPRESS] = strap_backpressure;
		pins[rscl_pkg::BIT_UP_SPEED] = strap_uplink_speed;
		pins[rscl_pkg::BIT_UP_DUPLEX] = strap_uplink_duplex;
		pins[rscl_pkg::BIT_UP_PAUSE] = strap_uplink_pause;
		pins[rscl_pkg::BIT_UP_RSVD] = strap_uplink_reserved;
		pins[rscl_pkg::BIT_PRI_EN] = tag_priority_enable;
		pins[rscl_pkg::BIT_MODE_LO] = uplink_port_mode[0];
		pins[rscl_pkg::BIT_MODE_HI] = uplink_port_mode[1];
		pins[rscl_pkg::BIT_PRIORITY_BUFFER_RESERVE] = priority_buffer_reserve;
		pins[rscl_pkg::BIT_PROG_SEL] = program_interface_select;
		pins[rscl_pkg::BIT_AUTOX] = auto_crossover_enable;
		pins[rscl_pkg::BIT_FEF] = far_end_fault;
		pins[rscl_pkg::BIT_TEST] = factory_test_enable;
		pins[rscl_pkg::BIT_SCAN] = scan_chain_enable;
		pins[rscl_pkg::BIT_REMOTE_LOOPBACK_TEST] = remote_loopback_test;
		pins[rscl_pkg::BIT_SWM] = switch_mode_test;
	end

	// ----------------------------------------
	// Effective settings
	// ----------------------------------------
	always_comb begin
		c = s.cfg;
		pri_en = s.ovr[rscl_pkg::OVR_PRI_VALID] ? s.ovr[rscl_pkg::OVR_PRI_VAL]
			: c[rscl_pkg::BIT_PRI_EN];
		pri_map = s.ovr[rscl_pkg::OVR_MAP_VALID] ? s.ovr[rscl_pkg::OVR_MAP_LSB +: 8]
			: rscl_pkg::PRI_MAP_DEFAULT;
		rsv_en = s.ovr[rscl_pkg::OVR_RSV_VALID] ? s.ovr[rscl_pkg::OVR_RSV_VAL]
			: c[rscl_pkg::BIT_PRIORITY_BUFFER_RESERVE];
		status = '0;
		status[0] = (s.state == rscl_pkg::ST_HOLD);
		status[1] = ~c[rscl_pkg::BIT_UP_RSVD];
		status[2] = c[rscl_pkg::BIT_TEST] | c[rscl_pkg::BIT_SCAN]
			| c[rscl_pkg::BIT_REMOTE_LOOPBACK_TEST] | ~c[rscl_pkg::BIT_SWM];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;
		case (s.state)
			rscl_pkg::ST_FILL: begin
				if (s.fill == rscl_pkg::SYNC_FILL) begin
					next_s.cfg = s.sync2;
					next_s.state = rscl_pkg::ST_HOLD;
				end else begin
					next_s.fill = s.fill + 2'h1;
				end
			end
			rscl_pkg::ST_HOLD: begin
				next_s.cfg = s.cfg;
			end
			default: begin
				next_s.state = rscl_pkg::ST_FILL;
				next_s.fill = '0;
			end
		endcase

		// Register read data is prepared in the setup phase
		if (psel && !penable) begin
			case (paddr)
				rscl_pkg::ADDR_STRAPS: next_s.rdata = {11'h000, s.cfg};
				rscl_pkg::ADDR_STATUS: next_s.rdata = status;
				rscl_pkg::ADDR_OVERRIDE: next_s.rdata = {16'h0000, s.ovr};
				rscl_pkg::ADDR_EFFECT: next_s.rdata = s.effect;
				default: next_s.rdata = '0;
			endcase
		end
		if (psel && penable && pwrite && paddr == rscl_pkg::ADDR_OVERRIDE) begin
			next_s.ovr = pwdata[15:0] & rscl_pkg::OVR_MASK;
		end

		next_s.effect = '0;
		next_s.effect[0] = c[rscl_pkg::BIT_FLOW];
		next_s.effect[1] = ~c[rscl_pkg::BIT_BCAST];
		next_s.effect[2] = ~c[rscl_pkg::BIT_BUFSHARE];
		next_s.effect[3] = c[rscl_pkg::BIT_AGING];
		next_s.effect[4] = ~c[rscl_pkg::BIT_FRAMELEN];
		next_s.effect[5] = c[rscl_pkg::BIT_BACKPRESS];
		next_s.effect[6] = c[rscl_pkg::BIT_UP_SPEED];
		next_s.effect[7] = c[rscl_pkg::BIT_UP_DUPLEX];
		next_s.effect[8] = ~c[rscl_pkg::BIT_UP_PAUSE];
		next_s.effect[9] = pri_en;
		next_s.effect[11:10] = {c[rscl_pkg::BIT_MODE_HI], c[rscl_pkg::BIT_MODE_LO]};
		next_s.effect[12] = rsv_en;
		next_s.effect[13] = ~c[rscl_pkg::BIT_PROG_SEL];
		next_s.effect[14] = c[rscl_pkg::BIT_AUTOX];
		next_s.effect[15] = ~c[rscl_pkg::BIT_FEF];
		next_s.effect[23:16] = pri_map;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s.sync1 <= '0;
			s.sync2 <= '0;
			s.state <= rscl_pkg::ST_FILL;
			s.fill <= '0;
			s.cfg <= rscl_pkg::CFG_RESET;
			s.ovr <= rscl_pkg::OVR_RESET;
			s.rdata <= '0;
			s.effect <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	always_comb begin
		case (paddr)
			rscl_pkg::ADDR_STRAPS,
			rscl_pkg::ADDR_STATUS,
			rscl_pkg::ADDR_OVERRIDE,
			rscl_pkg::ADDR_EFFECT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = s.rdata;

	// ----------------------------------------
	// Configuration outputs
	// ----------------------------------------
	assign config_valid = (s.state == rscl_pkg::ST_HOLD);
	assign flow_ctrl_en = s.effect[0];
	assign bcast_limit_en = s.effect[1];
	assign bcast_limit_pct = s.effect[1] ? rscl_pkg::BCAST_LIMIT_PCT : 7'h00;
	assign buffer_equal_alloc = s.effect[2];
	assign port_buffer_limit = s.effect[2] ? rscl_pkg::BUF_EQUAL : rscl_pkg::BUF_SHARED;
	assign addr_aging_en = s.effect[3];
	assign aging_seconds = rscl_pkg::AGING_SECONDS;
	assign max_len_untagged = s.effect[4] ? rscl_pkg::LEN_UNTAGGED : rscl_pkg::LEN_LONG;
	assign max_len_tagged = s.effect[4] ? rscl_pkg::LEN_TAGGED : rscl_pkg::LEN_LONG;
	assign backpressure_en = s.effect[5];
	assign uplink_speed_100 = s.effect[6];
	assign uplink_full_duplex = s.effect[7];
	assign uplink_pause_en = s.effect[8];
	assign qos_enable = s.effect[9];
	assign uplink_disabled = (s.effect[11:10] == 2'h0);
	assign uplink_reverse_mii = (s.effect[11:10] == 2'h1);
	assign uplink_forward_mii = (s.effect[11:10] == 2'h2);
	assign uplink_serial_mode = (s.effect[11:10] == 2'h3);
	assign priority_reserve_en = s.effect[12];
	assign priority_reserve_bytes = s.effect[12] ? rscl_pkg::PRI_RESERVE_BYTES : 13'h0000;
	assign processor_if_sel = s.effect[13];
	assign serial_prog_used = s.effect[13];
	assign auto_crossover_en = s.effect[14];
	assign far_end_fault_en = s.effect[15];
	assign priority_high_map = s.effect[23:16];
	assign strap_reserved_fault = status[1];
	assign strap_test_fault = status[2];

endmodule

// *** shared/rscl_pkg.sv ***
package rscl_pkg;

	// ----------------------------------------
	// Positions of each strap in the sampled word
	// ----------------------------------------
	localparam int unsigned STRAP_W = 21;
	localparam int unsigned BIT_FLOW = 0;
	localparam int unsigned BIT_BCAST = 1;
	localparam int unsigned BIT_BUFSHARE = 2;
	localparam int unsigned BIT_AGING = 3;
	localparam int unsigned BIT_FRAMELEN = 4;
	localparam int unsigned BIT_BACKPRESS = 5;
	localparam int unsigned BIT_UP_SPEED = 6;
	localparam int unsigned BIT_UP_DUPLEX = 7;
	localparam int unsigned BIT_UP_PAUSE = 8;
	localparam int unsigned BIT_UP_RSVD = 9;
	localparam int unsigned BIT_PRI_EN = 10;
	localparam int unsigned BIT_MODE_LO = 11;
	localparam int unsigned BIT_MODE_HI = 12;
	localparam int unsigned BIT_PRIORITY_BUFFER_RESERVE = 13;
	localparam int unsigned BIT_PROG_SEL = 14;
	localparam int unsigned BIT_AUTOX = 15;
	localparam int unsigned BIT_FEF = 16;
	localparam int unsigned BIT_TEST = 17;
	localparam int unsigned BIT_SCAN = 18;
	localparam int unsigned BIT_REMOTE_LOOPBACK_TEST = 19;
	localparam int unsigned BIT_SWM = 20;

	// Word held before capture: every strap at its default level
	localparam logic [20:0] CFG_RESET = 21'h10_A3FF;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_STRAPS = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_OVERRIDE = 8'h08;
	localparam logic [7:0] ADDR_EFFECT = 8'h0C;

	// Override register fields
	localparam int unsigned OVR_PRI_VALID = 0;
	localparam int unsigned OVR_PRI_VAL = 1;
	localparam int unsigned OVR_RSV_VALID = 2;
	localparam int unsigned OVR_RSV_VAL = 3;
	localparam int unsigned OVR_MAP_VALID = 4;
	localparam int unsigned OVR_MAP_LSB = 8;
	localparam logic [15:0] OVR_RESET = 16'h0000;
	localparam logic [15:0] OVR_MASK = 16'hFF1F;

	// ----------------------------------------
	// Decoded values
	// ----------------------------------------
	localparam logic [6:0] BCAST_LIMIT_PCT = 7'h05;
	localparam logic [9:0] BUF_EQUAL = 10'h071;
	localparam logic [9:0] BUF_SHARED = 10'h200;
	localparam logic [8:0] AGING_SECONDS = 9'h12C;
	localparam logic [10:0] LEN_UNTAGGED = 11'h5EE;
	localparam logic [10:0] LEN_TAGGED = 11'h5F2;
	localparam logic [10:0] LEN_LONG = 11'h600;
	localparam logic [12:0] PRI_RESERVE_BYTES = 13'h1800;
	localparam logic [7:0] PRI_MAP_DEFAULT = 8'hF0;

	// Synchroniser stages before the capture edge
	localparam logic [1:0] SYNC_FILL = 2'h2;

	typedef enum logic [1:0] {
		ST_FILL = 2'b00,
		ST_HOLD = 2'b01
	} rscl_state_t;

endpackage

// *** testbench/rscl_board.sv ***
`timescale 1ns/10ps
module rscl_board (
	// Resistor pattern, 1 = float or pull-up
	input wire logic [20:0] level,
	input wire logic misuse,
	// Pad levels
	output logic [20:0] pins
);
	always_comb begin
		pins = level;
		if (!misuse) begin
			pins[rscl_pkg::BIT_UP_RSVD] = 1'h1;
			pins[19:17] = 3'h0;
			pins[rscl_pkg::BIT_SWM] = 1'h1;
		end
	end
endmodule

// *** testbench/rscl_latch_sva.sv ***
`timescale 1ns/10ps
module rscl_latch_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Straps
	input wire logic strap_flow_ctrl,
	input wire logic strap_uplink_pause,
	input wire logic far_end_fault,
	// Decoded configuration
	input wire logic config_valid,
	input wire logic flow_ctrl_en,
	input wire logic buffer_equal_alloc,
	input wire logic [9:0] port_buffer_limit,
	input wire logic [10:0] max_len_untagged,
	input wire logic [10:0] max_len_tagged,
	input wire logic uplink_pause_en,
	input wire logic uplink_disabled,
	input wire logic uplink_reverse_mii,
	input wire logic uplink_forward_mii,
	input wire logic uplink_serial_mode,
	input wire logic priority_reserve_en,
	input wire logic [12:0] priority_reserve_bytes,
	input wire logic far_end_fault_en
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_held; config_valid |=> config_valid; endproperty
	a_held: assert property (p_held) else $error("valid dropped");
	property p_frozen;
		config_valid && $past(config_valid, 2) |-> $stable(flow_ctrl_en) && $stable(uplink_pause_en);
	endproperty
	a_frozen: assert property (p_frozen) else $error("config moved");
	property p_flow; $rose(config_valid) |=> flow_ctrl_en == $past(strap_flow_ctrl, 4); endproperty
	a_flow: assert property (p_flow) else $error("flow control wrong");
	property p_pause;
		$rose(config_valid) |=> uplink_pause_en != $past(strap_uplink_pause, 4);
	endproperty
	a_pause: assert property (p_pause) else $error("uplink pause wrong");
	property p_fef; $rose(config_valid) |=> far_end_fault_en != $past(far_end_fault, 4); endproperty
	a_fef: assert property (p_fef) else $error("fault signalling wrong");
	property p_buf; port_buffer_limit == (buffer_equal_alloc ? 10'h071 : 10'h200); endproperty
	a_buf: assert property (p_buf) else $error("buffer limit wrong");
	property p_len; max_len_tagged == (max_len_untagged == 11'h5EE ? 11'h5F2 : 11'h600); endproperty
	a_len: assert property (p_len) else $error("length limits wrong");
	property p_mode;
		$onehot({uplink_disabled, uplink_reverse_mii, uplink_forward_mii, uplink_serial_mode});
	endproperty
	a_mode: assert property (p_mode) else $error("uplink mode not one-hot");
	property p_rsv; priority_reserve_bytes == (priority_reserve_en ? 13'h1800 : 13'h0000); endproperty
	a_rsv: assert property (p_rsv) else $error("reserve size wrong");
	c_capture: cover property ($rose(config_valid));
	c_serial: cover property (uplink_serial_mode);
	c_equal: cover property (buffer_equal_alloc);
endmodule

bind rscl_latch rscl_latch_sva u_sva (.*);

// *** testbench/rscl_latch_tb_top.sv ***
`timescale 1ns/10ps
module rscl_latch_tb_top;
	logic mclk, rst, psel, penable, pwrite, misuse, pready, pslverr, err;
	logic [7:0] paddr, priority_high_map;
	logic [31:0] pwdata, prdata, rd;
	logic config_valid, flow_ctrl_en, bcast_limit_en, buffer_equal_alloc, addr_aging_en;
	logic [6:0] bcast_limit_pct;
	logic [9:0] port_buffer_limit;
	logic [8:0] aging_seconds;
	logic [10:0] max_len_untagged, max_len_tagged;
	logic backpressure_en, uplink_speed_100, uplink_full_duplex, uplink_pause_en, qos_enable;
	logic uplink_disabled, uplink_reverse_mii, uplink_forward_mii, uplink_serial_mode;
	logic [12:0] priority_reserve_bytes;
	logic priority_reserve_en, processor_if_sel, serial_prog_used, auto_crossover_en;
	logic far_end_fault_en, strap_reserved_fault, strap_test_fault;
	logic strap_flow_ctrl, strap_bcast_storm, strap_buffer_share, strap_addr_aging;
	logic strap_frame_len, strap_backpressure, strap_uplink_speed, strap_uplink_duplex;
	logic strap_uplink_pause, strap_uplink_reserved, tag_priority_enable, priority_buffer_reserve;
	logic program_interface_select, auto_crossover_enable, far_end_fault, factory_test_enable;
	logic scan_chain_enable, remote_loopback_test, switch_mode_test;
	logic [1:0] uplink_port_mode;
	logic [20:0] level, pins;
	int n_errors, total_checks;

	assign {switch_mode_test, remote_loopback_test, scan_chain_enable, factory_test_enable,
		far_end_fault, auto_crossover_enable, program_interface_select, priority_buffer_reserve,
		uplink_port_mode, tag_priority_enable, strap_uplink_reserved, strap_uplink_pause,
		strap_uplink_duplex, strap_uplink_speed, strap_backpressure, strap_frame_len,
		strap_addr_aging, strap_buffer_share, strap_bcast_storm, strap_flow_ctrl} = pins;
	rscl_board board (.level(level), .misuse(misuse), .pins(pins));
	rscl_latch DUT (.*);

	initial mclk = 1'h0;
	always #20 mclk = ~mclk;

	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic hung();
		n_errors++;
		summarize();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic boot(input logic [20:0] w, input logic m);
		int n;
		level <= w;
		misuse <= m;
		rst <= 1'h1;
		repeat (4) @(posedge mclk);
		rst <= 1'h0;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (config_valid !== 1'h1 && n < 20);
		if (n >= 20) hung();
		repeat (2) @(posedge mclk);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) hung();
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask

	task automatic t_defaults();
		boot(rscl_pkg::CFG_RESET, 1'h0);
		chk(config_valid, 1'h1);
		chk(flow_ctrl_en, 1'h1);
		chk(bcast_limit_pct, 7'h00);
		chk({buffer_equal_alloc, port_buffer_limit}, 11'h200);
		chk({addr_aging_en, aging_seconds}, 10'h32C);
		chk({max_len_untagged, max_len_tagged}, 22'h30_0600);
		chk(backpressure_en, 1'h1);
		chk({uplink_speed_100, uplink_full_duplex, uplink_pause_en}, 3'h6);
		chk(priority_reserve_bytes, 13'h1800);
		chk({auto_crossover_en, far_end_fault_en, strap_test_fault}, 3'h6);
		chk(strap_reserved_fault, 1'h0);
		apb(1'h0, rscl_pkg::ADDR_STRAPS, 32'h0000_0000);
		chk(rd, 32'h0010_A3FF);
		apb(1'h0, rscl_pkg::ADDR_EFFECT, 32'h0000_0000);
		chk(rd, 32'h00F0_F0E9);
	endtask

	task automatic t_pulldown();
		boot(21'h00_0000, 1'h0);
		chk({flow_ctrl_en, bcast_limit_en, bcast_limit_pct}, 9'h085);
		chk({addr_aging_en, port_buffer_limit}, 11'h071);
		chk({max_len_untagged, max_len_tagged}, 22'h2F_75F2);
		chk({backpressure_en, uplink_speed_100, uplink_full_duplex}, 3'h0);
		chk(uplink_pause_en, 1'h1);
		chk({processor_if_sel, auto_crossover_en, far_end_fault_en}, 3'h5);
		chk(serial_prog_used, 1'h1);
		level <= 21'h1F_FFFF;
		repeat (6) @(posedge mclk);
		chk({flow_ctrl_en, port_buffer_limit}, 11'h071);
	endtask

	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			boot({rscl_pkg::CFG_RESET[20:15], 2'h2, m[1:0], 1'h1, rscl_pkg::CFG_RESET[9:0]}, 1'h0);
			chk({uplink_serial_mode, uplink_forward_mii, uplink_reverse_mii, uplink_disabled},
				4'h1 << m);
			chk({qos_enable, processor_if_sel, priority_reserve_en}, 3'h4);
			chk(serial_prog_used, 1'h0);
			chk(priority_high_map, 8'hF0);
		end
	endtask

	task automatic t_override();
		boot(rscl_pkg::CFG_RESET, 1'h0);
		apb(1'h1, rscl_pkg::ADDR_OVERRIDE, 32'hFFFF_0FF7);
		@(posedge mclk);
		chk({qos_enable, priority_reserve_en, priority_high_map}, 10'h20F);
		apb(1'h0, rscl_pkg::ADDR_OVERRIDE, 32'h0000_0000);
		chk(rd, 32'h0000_0F17);
		apb(1'h1, rscl_pkg::ADDR_STRAPS, 32'h0000_0000);
		apb(1'h0, rscl_pkg::ADDR_STRAPS, 32'h0000_0000);
		chk(rd, 32'h0010_A3FF);
		apb(1'h0, 8'h40, 32'h0000_0000);
		chk(err, 1'h1);
		chk(rd, 32'h0000_0000);
	endtask

	task automatic t_misuse();
		boot(rscl_pkg::CFG_RESET ^ 21'h02_0200, 1'h1);
		chk({strap_reserved_fault, strap_test_fault}, 2'h3);
		apb(1'h0, rscl_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0007);
	endtask

	initial begin
		rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		level = rscl_pkg::CFG_RESET;
		misuse = 1'h0;
		@(posedge mclk);
		t_defaults();
		t_pulldown();
		t_modes();
		t_override();
		t_misuse();
		summarize();
	end
endmodule
